// *** hdl/ccr_bank.sv ***
/*
 Control and status register bank of a single-cell charger. Registers are
 reached through the byte port that the single-wire command engine drives.
 Assumes that engine presents one write or read strobe per access with a
 stable address and slave address, and that status inputs are analog levels.
*/
// Overview of operation
// - voltage code: 25 mV steps, 1110/1111 special
// - headroom bit clears the 150 mV headroom
// - trickle threshold bit picks 2.8 V or 3 V
// - reverse block threshold bit picks minus/plus 5 mV
// - input limit bit removes the 800 mA limit
// - current code scales the reference current
// - termination bit picks 0.05 or 0.1
// - tracking bit picks 1.053xVBAT at 275 mA
// - mode field uses the charger state codes
// - apply bit forces a legal state code (not 01xx or 1110), then clears
// - bank answers slave address 04h only
`timescale 1ns/1ps
`default_nettype none
module ccr_bank #(
    parameter logic [6:0] SLAVE_ADDR = `CCR_SLAVE_ADDR,
    parameter logic [7:0] ID_VALUE   = 8'h5c  // arbitrary identity value
) (
    input  wire logic        REF_CLK,
    input  wire logic        ARST_N,
    input  wire logic [6:0]  SLV_ADDR,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  CHG_STATUS_IN,
    input  wire logic [3:0]  FSM_STATE_IN,
    input  wire logic [3:0]  BAT_FLAGS_IN,
    input  wire logic        CV_BAR_IN,
    output logic      [7:0]  REG_RDATA,
    output logic             REG_ACK,
    output logic      [12:0] REG_VOLT_MV,
    output logic      [7:0]  HEADROOM_MV,
    output logic      [11:0] TRICKLE_MV,
    output logic             REV_BLOCK_PLUS,
    output logic      [9:0]  INPUT_LIMIT_MA,
    output logic             INPUT_LIMIT_OFF,
    output logic             SYSTEM_TRACKING_ENABLE_EN,
    output logic      [4:0]  CC_MULT_X10,
    output logic      [3:0]  TERM_X100,
    output logic             CC_DISABLE,
    output logic             BYPASS_READY,
    output logic             BAT_OV_DISABLE,
    output logic      [7:0]  CONFIG_OUT,
    output logic             FORCE_PULSE,
    output logic      [3:0]  FORCE_STATE,
    output logic             POR_PULSE
);
    localparam ccr_pkg::ccr_state_type RST_STATE = '{
        volt: `CCR_VOLT_RST, cur: `CCR_CUR_RST, mode: `CCR_MODE_RST,
        cfg: `CCR_CFG_RST, rdata: 8'h00, ack: 1'b0, force_p: 1'b0,
        force_st: 4'h0, por_p: 1'b0, vmv: `CCR_REGULATION_VOLTAGE_FIELD_RST_MV,
        hmv: `CCR_HEADROOM_MV, tmv: `CCR_TRICKLE_LO_MV, ilim: `CCR_ILIM_MA,
        ilim_off: 1'b0, rcb: 1'b0, track: 1'b0, ccm: `CCR_CC_RST_X10,
        term: `CCR_TERM_LO_X100, ccdis: 1'b0, bypass: 1'b0, ovdis: 1'b0};

    ccr_pkg::ccr_state_type st_reg;
    ccr_pkg::ccr_state_type st_next;
    logic [16:0]            live;
    logic                   hit;
    logic [7:0]             rd_val;

    if (SLAVE_ADDR > 7'h3f)
    begin : g_chk
        $error("normal addressing carries a 6-bit device address");
    end

    // live status levels come from the analog side
    ccr_sync #(
        .WIDTH (17)
    ) u_sync (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .d      ({CHG_STATUS_IN, FSM_STATE_IN, BAT_FLAGS_IN, CV_BAR_IN}),
        .q      (live)
    );

    // accesses for another slave on the shared line are not ours
    assign hit = (SLV_ADDR == SLAVE_ADDR);

    // read mux; status bytes are sampled at read time, never latched
    always_comb
    begin
        case (REG_ADDR)
            `CCR_VOLT_OFS:     rd_val = st_reg.volt;
            `CCR_CUR_OFS:      rd_val = st_reg.cur;
            `CCR_MODE_OFS:     rd_val = st_reg.mode;
            `CCR_CFG_OFS:      rd_val = st_reg.cfg;
            `CCR_CHG_STAT_OFS: rd_val = live[16:9];
            `CCR_FSM_STAT_OFS: rd_val = live[8:1];
            `CCR_REG_STAT_OFS: rd_val = {live[0], 7'h00};
            `CCR_ID_OFS:       rd_val = ID_VALUE;
            default:           rd_val = 8'h00;
        endcase
    end

    // register writes, self-clearing commands and the decoded settings
    always_comb
    begin
        st_next         = st_reg;
        st_next.ack     = 1'b0;
        st_next.force_p = 1'b0;
        st_next.por_p   = 1'b0;
        if (hit && REG_WR)
        begin
            st_next.ack = 1'b1;
            case (REG_ADDR)
                `CCR_VOLT_OFS: st_next.volt = REG_WDATA;
                `CCR_CUR_OFS:  st_next.cur = REG_WDATA & `CCR_CUR_WMASK;
                `CCR_CFG_OFS:  st_next.cfg = REG_WDATA & `CCR_CFG_WMASK;
                `CCR_MODE_OFS:
                begin
                    // command bits are not stored, so they read back as zero
                    st_next.mode = REG_WDATA & `CCR_MODE_WMASK;
                    if (REG_WDATA[`CCR_APPLY_BIT]
                        && ccr_pkg::ccr_mode_legal(REG_WDATA[7:4]))
                    begin
                        st_next.force_p  = 1'b1;
                        st_next.force_st = REG_WDATA[7:4];
                    end
                    // a hard reset also restores the settings it implies
                    if (REG_WDATA[`CCR_REGRST_BIT] || REG_WDATA[`CCR_HARDRST_BIT])
                    begin
                        st_next.volt = `CCR_VOLT_RST;
                        st_next.cur  = `CCR_CUR_RST;
                        st_next.mode = `CCR_MODE_RST;
                        st_next.cfg  = `CCR_CFG_RST;
                    end
                    st_next.por_p = REG_WDATA[`CCR_HARDRST_BIT];
                end
                default: ; // status and unmapped bytes drop the write
            endcase
        end
        else if (hit && REG_RD)
        begin
            st_next.ack   = 1'b1;
            st_next.rdata = rd_val;
        end
        // decode from the next value so settings move with the register
        st_next.vmv = ccr_pkg::ccr_regulation_voltage_field_mv(st_next.volt[7:4]);
        st_next.hmv = st_next.volt[`CCR_HEADROOM_BIT] ? 8'h00
                                                      : `CCR_HEADROOM_MV;
        st_next.tmv = st_next.volt[`CCR_TRICKLE_BIT] ? `CCR_TRICKLE_HI_MV
                                                     : `CCR_TRICKLE_LO_MV;
        st_next.rcb      = st_next.volt[`CCR_RCB_BIT];
        st_next.ilim_off = st_next.volt[`CCR_ILIM_BIT];
        st_next.track    = st_next.cur[`CCR_TRACK_BIT];
        st_next.ilim     = st_next.track ? `CCR_TRACK_ILIM_MA : `CCR_ILIM_MA;
        st_next.ccm      = ccr_pkg::ccr_cc_x10(st_next.cur[7:5]);
        st_next.term     = st_next.cur[`CCR_TERM_BIT] ? `CCR_TERM_HI_X100
                                                      : `CCR_TERM_LO_X100;
        st_next.ccdis    = st_next.cfg[`CCR_CCDIS_BIT];
        st_next.ovdis    = st_next.mode[`CCR_OVDIS_BIT];
        // bypass only when the host has set all three bits
        st_next.bypass   = st_next.volt[`CCR_HEADROOM_BIT]
                           && st_next.volt[`CCR_RCB_BIT] && st_next.ccdis;
    end

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            st_reg <= RST_STATE;
        else
            st_reg <= st_next;
    end

    // every output is a field of the state register
    assign REG_RDATA       = st_reg.rdata;
    assign REG_ACK         = st_reg.ack;
    assign REG_VOLT_MV     = st_reg.vmv;
    assign HEADROOM_MV     = st_reg.hmv;
    assign TRICKLE_MV      = st_reg.tmv;
    assign REV_BLOCK_PLUS  = st_reg.rcb;
    assign INPUT_LIMIT_MA  = st_reg.ilim;
    assign INPUT_LIMIT_OFF = st_reg.ilim_off;
    assign SYSTEM_TRACKING_ENABLE_EN    = st_reg.track;
    assign CC_MULT_X10     = st_reg.ccm;
    assign TERM_X100       = st_reg.term;
    assign CC_DISABLE      = st_reg.ccdis;
    assign BYPASS_READY    = st_reg.bypass;
    assign BAT_OV_DISABLE  = st_reg.ovdis;
    assign CONFIG_OUT      = st_reg.cfg;
    assign FORCE_PULSE     = st_reg.force_p;
    assign FORCE_STATE     = st_reg.force_st;
    assign POR_PULSE       = st_reg.por_p;

    // checks on the bank's own outputs
    logic wr_volt;
    logic wr_cur;
    logic wr_mode;
    logic wr_cfg;
    assign wr_volt = hit && REG_WR && (REG_ADDR == `CCR_VOLT_OFS);
    assign wr_cur  = hit && REG_WR && (REG_ADDR == `CCR_CUR_OFS);
    assign wr_mode = hit && REG_WR && (REG_ADDR == `CCR_MODE_OFS);
    assign wr_cfg  = hit && REG_WR && (REG_ADDR == `CCR_CFG_OFS);

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!ARST_N);

    a_regulation_voltage_field_top_code: assert property (
        wr_volt && REG_WDATA[7:4] == 4'hd |=> REG_VOLT_MV == 13'h11ad)
        else $error("voltage code 1101 not decoded as 4525 mV");

    a_headroom_keep: assert property (
        wr_volt |=> HEADROOM_MV == ($past(REG_WDATA[3]) ? 8'h00 : 8'h96))
        else $error("headroom does not follow its bit");

    a_trickle_sel: assert property (
        wr_volt |=> TRICKLE_MV == ($past(REG_WDATA[2]) ? 12'hbb8 : 12'haf0))
        else $error("trickle threshold does not follow its bit");

    a_rcb_sel: assert property (
        wr_volt |=> REV_BLOCK_PLUS == $past(REG_WDATA[1]))
        else $error("reverse block threshold not updated");

    a_ilim_off: assert property (
        wr_volt && REG_WDATA[0] |=> INPUT_LIMIT_OFF ##1 INPUT_LIMIT_OFF)
        else $error("input limit not removed");

    a_cc_scale: assert property (
        wr_cur && REG_WDATA[7:5] == 3'h7 |=> CC_MULT_X10 == 5'h1e)
        else $error("current code 111 not three times");

    a_term_sel: assert property (
        wr_cur |=> TERM_X100 == ($past(REG_WDATA[4]) ? 4'ha : 4'h5))
        else $error("termination does not follow its bit");

    a_track_limit: assert property (
        SYSTEM_TRACKING_ENABLE_EN |-> INPUT_LIMIT_MA == 10'h113)
        else $error("tracking without 275 mA limit");

    a_force_once: assert property (
        wr_mode && REG_WDATA[3] && REG_WDATA[7:4] == 4'hf
        |=> FORCE_PULSE && FORCE_STATE == 4'hf ##1 !FORCE_PULSE)
        else $error("stop charge force not a single pulse");

    a_reg_reset: assert property (
        wr_mode && REG_WDATA[1] |=> REG_VOLT_MV == 13'h10fe && !SYSTEM_TRACKING_ENABLE_EN)
        else $error("register reset left settings");

    a_por_pulse: assert property (
        wr_mode && REG_WDATA[0] |=> POR_PULSE ##1 !POR_PULSE)
        else $error("hard reset not a single pulse");

    a_id_read: assert property (
        hit && REG_RD && !REG_WR && REG_ADDR == `CCR_ID_OFS
        |=> REG_ACK && REG_RDATA == ID_VALUE)
        else $error("identity read wrong");

    a_foreign_addr: assert property (
        (REG_WR || REG_RD) && !hit |=> !REG_ACK)
        else $error("answered a foreign slave address");

    // the special voltage codes sit below the stepped range
    a_regulation_voltage_field_low_code: assert property (
        wr_volt && REG_WDATA[7:4] == 4'he |=> REG_VOLT_MV == 13'h0fa0)
        else $error("voltage code 1110 not decoded as 4000 mV");

    // reserved codes are stored but must never reach the state machine
    a_mode_reserved: assert property (
        wr_mode && REG_WDATA[3] && (REG_WDATA[7:6] == 2'h1 || REG_WDATA[7:4] == 4'he)
        |=> !FORCE_PULSE)
        else $error("reserved mode code was forced");

    // sleep is a forcible state and must carry its own code
    a_force_sleep: assert property (
        wr_mode && REG_WDATA[7:3] == 5'h05 |=> FORCE_PULSE && FORCE_STATE == 4'h2)
        else $error("sleep force not issued");

    // cc disable reaches the charge path straight from the config byte
    a_ccdis_follow: assert property (
        wr_cfg |=> CC_DISABLE == $past(REG_WDATA[5]) && CONFIG_OUT[7] == 1'b0
        && CONFIG_OUT[4] == 1'b0)
        else $error("cc disable or config mask wrong");

    // bypass needs all three host bits at once
    a_bypass_set: assert property (
        BYPASS_READY |-> HEADROOM_MV == 8'h00 && REV_BLOCK_PLUS && CC_DISABLE)
        else $error("bypass flagged without its three bits");

    // every accepted strobe is answered on the next edge
    a_ack_pulse: assert property (
        (REG_WR || REG_RD) && hit |=> REG_ACK)
        else $error("accepted access not acknowledged");

    // the cv status byte carries only its top bit
    a_cv_byte: assert property (
        hit && REG_RD && !REG_WR && REG_ADDR == `CCR_REG_STAT_OFS
        |=> REG_RDATA[6:0] == 7'h00)
        else $error("reserved cv status bits not zero");

    c_force_stop: cover property (wr_mode && REG_WDATA[7:3] == 5'h1f ##1 FORCE_PULSE);
    c_bypass: cover property (BYPASS_READY);
    c_status_read: cover property (hit && REG_RD && REG_ADDR == `CCR_FSM_STAT_OFS);
    c_exit_stop: cover property (wr_mode && REG_WDATA[7:3] == 5'h19 ##1 FORCE_PULSE);
    c_hard_reset: cover property (POR_PULSE);
endmodule
`default_nettype wire

// *** hdl/ccr_map.svh ***
/*
 Register offsets, field positions, reset values and decode figures of the
 charger control register bank. Assumes inclusion by name from ccr_pkg only.
*/
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// register offsets
`define CCR_VOLT_OFS        8'h00
`define CCR_CUR_OFS         8'h01
`define CCR_MODE_OFS        8'h02
`define CCR_CFG_OFS         8'h03
`define CCR_CHG_STAT_OFS    8'h05
`define CCR_FSM_STAT_OFS    8'h06
`define CCR_REG_STAT_OFS    8'h07
`define CCR_ID_OFS          8'h08
`define CCR_SLAVE_ADDR      7'h04

// reset values and writable masks
`define CCR_VOLT_RST        8'h60
`define CCR_CUR_RST         8'h00
`define CCR_MODE_RST        8'ha0
`define CCR_CFG_RST         8'h00
`define CCR_CUR_WMASK       8'hfe
`define CCR_MODE_WMASK      8'hf4
`define CCR_CFG_WMASK       8'h6f

// field positions
`define CCR_HEADROOM_BIT    3
`define CCR_TRICKLE_BIT     2
`define CCR_RCB_BIT         1
`define CCR_ILIM_BIT        0
`define CCR_TERM_BIT        4
`define CCR_TRACK_BIT       1
`define CCR_APPLY_BIT       3
`define CCR_OVDIS_BIT       2
`define CCR_REGRST_BIT      1
`define CCR_HARDRST_BIT     0
`define CCR_CCDIS_BIT       5

// decode figures in mV, mA, tenths and hundredths
`define CCR_REGULATION_VOLTAGE_FIELD_BASE_MV    13'h1068
`define CCR_REGULATION_VOLTAGE_FIELD_STEP_MV    13'h0019
`define CCR_REGULATION_VOLTAGE_FIELD_E_MV       13'h0fa0
`define CCR_REGULATION_VOLTAGE_FIELD_F_MV       13'h1004
`define CCR_REGULATION_VOLTAGE_FIELD_RST_MV     13'h10fe
`define CCR_HEADROOM_MV     8'h96
`define CCR_TRICKLE_LO_MV   12'haf0
`define CCR_TRICKLE_HI_MV   12'hbb8
`define CCR_ILIM_MA         10'h320
`define CCR_TRACK_ILIM_MA   10'h113
`define CCR_TERM_LO_X100    4'h5
`define CCR_TERM_HI_X100    4'ha
`define CCR_CC_RST_X10      5'h05

`endif

// *** hdl/ccr_pkg.sv ***
/*
 Types and decode functions of the charger control register bank.
 Assumes ccr_map.svh is on the include path.
*/
package ccr_pkg;
`include "ccr_map.svh"

    // charger state codes as seen in the mode field
    typedef enum logic [3:0] {
        CCR_RESET        = 4'h0,
        CCR_SHIPPING     = 4'h1,
        CCR_SLEEP        = 4'h2,
        CCR_CURRENT_TEST = 4'h3,
        CCR_DISCHARGE    = 4'h8,
        CCR_FAULT        = 4'h9,
        CCR_START        = 4'ha,
        CCR_SYS_PRECHG   = 4'hb,
        CCR_CHARGE       = 4'hc,
        CCR_CHARGE_DONE  = 4'hd,
        CCR_STOP_CHARGE  = 4'hf
    } ccr_mode_type;

    typedef struct packed {
        logic [7:0]  volt;
        logic [7:0]  cur;
        logic [7:0]  mode;
        logic [7:0]  cfg;
        logic [7:0]  rdata;
        logic        ack;
        logic        force_p;
        logic [3:0]  force_st;
        logic        por_p;
        logic [12:0] vmv;
        logic [7:0]  hmv;
        logic [11:0] tmv;
        logic [9:0]  ilim;
        logic        ilim_off;
        logic        rcb;
        logic        track;
        logic [4:0]  ccm;
        logic [3:0]  term;
        logic        ccdis;
        logic        bypass;
        logic        ovdis;
    } ccr_state_type;

    // regulation voltage in mV from the 4-bit code
    function automatic logic [12:0] ccr_regulation_voltage_field_mv(input logic [3:0] code);
        logic [12:0] v;
        v = `CCR_REGULATION_VOLTAGE_FIELD_BASE_MV + `CCR_REGULATION_VOLTAGE_FIELD_STEP_MV * {9'h000, code};
        if (code == 4'he)
            v = `CCR_REGULATION_VOLTAGE_FIELD_E_MV;
        else if (code == 4'hf)
            v = `CCR_REGULATION_VOLTAGE_FIELD_F_MV;
        return v;
    endfunction

    // fast charge current in tenths of the reference current
    function automatic logic [4:0] ccr_cc_x10(input logic [2:0] code);
        logic [4:0] m;
        case (code)
            3'h0:    m = 5'h05;
            3'h1:    m = 5'h02;
            3'h2:    m = 5'h07;
            3'h3:    m = 5'h09;
            3'h4:    m = 5'h0a;
            3'h5:    m = 5'h0f;
            3'h6:    m = 5'h14;
            default: m = 5'h1e;
        endcase
        return m;
    endfunction

    // reserved and unassigned codes never reach the state machine
    function automatic logic ccr_mode_legal(input logic [3:0] code);
        return (code[3:2] != 2'h1) && (code != 4'he);
    endfunction
endpackage

// *** hdl/ccr_sync.sv ***
/*
 Two-flop synchroniser for the live analog status levels.
 Assumes the inputs are quasi-static levels; multi-bit codes may show one
 mixed sample while they change.
*/
`timescale 1ns/1ps
`default_nettype none
module ccr_sync #(
    parameter int WIDTH = 17
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } ccr_sync_state_type;

    ccr_sync_state_type r_reg;
    ccr_sync_state_type r_next;

    if (WIDTH < 1)
    begin : g_chk
        $error("ccr_sync needs WIDTH of at least 1");
    end

    // first stage feeds only the second stage
    always_comb
    begin
        r_next    = r_reg;
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign q = r_reg.s2;
endmodule
`default_nettype wire

// *** verification/ccr_bank_test.sv ***
/*
 Self-checking bench of the charger register bank, driven through ccr_host.
 Assumes ccr_pkg and the bank are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %0t %s", $time, m); end end
module ccr_bank_test;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} ccr_row_type;
    logic        clk;
    logic        arst_n;
    logic [7:0]  chg;
    logic [3:0]  fsm;
    logic [3:0]  batf;
    logic        cvb;
    logic [6:0]  sa;
    logic [7:0]  ra;
    logic [7:0]  wd;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        ack;
    logic [12:0] vmv;
    logic [7:0]  hmv;
    logic [11:0] tmv;
    logic        rcb;
    logic [9:0]  ilim;
    logic        ilim_off;
    logic        track;
    logic [4:0]  ccm;
    logic [3:0]  term;
    logic        ccdis;
    logic        byp;
    logic        ovdis;
    logic [7:0]  cfg;
    logic        fp;
    logic [3:0]  fst;
    logic        por;
    int          error_cnt = 0;
    int          checks = 0;
    logic [12:0] ev;
    logic [3:0]  c;
    logic        legal;
    logic [4:0]  cc_tab [8] = '{5'h05, 5'h02, 5'h07, 5'h09, 5'h0a, 5'h0f, 5'h14, 5'h1e};
    logic [3:0]  st_tab [4] = '{4'hf, 4'h2, 4'h3, 4'h1};
    logic [3:0]  ex_tab [4] = '{4'hc, 4'h8, 4'ha, 4'ha};
    ccr_row_type rows [10] = '{'{8'h01, 8'hff, 8'hfe}, '{8'h03, 8'hff, 8'h6f},
        '{8'h02, 8'hf4, 8'hf4}, '{8'h00, 8'hd0, 8'hd0}, '{8'h05, 8'hff, 8'h3c},
        '{8'h06, 8'h00, 8'h96}, '{8'h07, 8'h00, 8'h80}, '{8'h08, 8'hff, 8'h3a},
        '{8'h09, 8'h5a, 8'h00}, '{8'hff, 8'h5a, 8'h00}};

    // 10 MHz reference clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ccr_host host (.clk(clk), .ack(ack), .rdata(rdata), .slv_addr(sa), .reg_addr(ra),
        .wdata(wd), .wr(wr), .rd(rd));

    // identity value is arbitrary
    ccr_bank #(.SLAVE_ADDR(7'h04), .ID_VALUE(8'h3a)) dut (.REF_CLK(clk), .ARST_N(arst_n),
        .SLV_ADDR(sa), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
        .CHG_STATUS_IN(chg), .FSM_STATE_IN(fsm), .BAT_FLAGS_IN(batf), .CV_BAR_IN(cvb),
        .REG_RDATA(rdata), .REG_ACK(ack), .REG_VOLT_MV(vmv), .HEADROOM_MV(hmv),
        .TRICKLE_MV(tmv), .REV_BLOCK_PLUS(rcb), .INPUT_LIMIT_MA(ilim),
        .INPUT_LIMIT_OFF(ilim_off), .SYSTEM_TRACKING_ENABLE_EN(track), .CC_MULT_X10(ccm),
        .TERM_X100(term), .CC_DISABLE(ccdis), .BYPASS_READY(byp), .BAT_OV_DISABLE(ovdis),
        .CONFIG_OUT(cfg), .FORCE_PULSE(fp), .FORCE_STATE(fst), .POR_PULSE(por));

    task automatic end_sim();
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // a hang costs a mismatch and ends the run
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial
    begin
        arst_n = 1'b0;
        chg = 8'h3c;
        fsm = 4'h9;
        batf = 4'h6;
        cvb = 1'b1;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        // every voltage code, low nibble mirrors the code to walk the option bits
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            ev = (c < 4'he) ? 13'h1068 + 13'h0019 * {9'h000, c} : ((c == 4'he) ? 13'h0fa0 : 13'h1004);
            host.wr8(8'h00, {c, c});
            `CHK(vmv, ev, "volt code")
            `CHK(hmv, c[3] ? 8'h00 : 8'h96, "headroom")
            `CHK(tmv, c[2] ? 12'hbb8 : 12'haf0, "trickle")
            `CHK(rcb, c[1], "reverse block")
            `CHK(ilim_off, c[0], "limit off")
        end
        // every current code with termination and tracking toggled
        for (int i = 0; i < 8; i++)
        begin
            c = i[3:0];
            host.wr8(8'h01, {c[2:0], c[0], 2'h0, c[1], 1'b0});
            `CHK(ccm, cc_tab[i], "cc multiple")
            `CHK(term, c[0] ? 4'ha : 4'h5, "termination")
            `CHK(track, c[1], "tracking")
            `CHK(ilim, c[1] ? 10'h113 : 10'h320, "input limit")
        end
        // readback table: masks, read-only writes ignored, unmapped reads zero
        foreach (rows[i])
        begin
            host.wr8(rows[i].a, rows[i].d);
            host.rd8(rows[i].a);
            `CHK(host.last_ack, 1'b1, "ack")
            `CHK(host.last_rd, rows[i].r, "readback")
        end
        `CHK(ovdis, 1'b1, "ov disable")
        // new live levels on a rising edge, then time for both sync stages
        @(posedge clk);
        chg <= 8'hc3;
        fsm <= 4'h3;
        batf <= 4'h9;
        cvb <= 1'b0;
        repeat (4) @(posedge clk);
        host.rd8(8'h05);
        `CHK(host.last_rd, 8'hc3, "live status")
        host.rd8(8'h06);
        `CHK(host.last_rd, 8'h39, "live state")
        host.rd8(8'h07);
        `CHK(host.last_rd, 8'h00, "live cv")
        // every mode code with apply: reserved codes never force
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            legal = !((c >= 4'h4 && c <= 4'h7) || c == 4'he);
            host.wr8(8'h02, {c, 4'h8});
            `CHK(fp, legal, "force pulse")
            if (legal)
                `CHK(fst, c, "force state")
            host.rd8(8'h02);
            `CHK(host.last_rd, {c, 4'h0}, "apply clears")
        end
        // forced states and their exits
        for (int i = 0; i < 4; i++)
        begin
            host.force_state(st_tab[i], 1'b1);
            `CHK(fst, st_tab[i], "forced")
            host.leave(st_tab[i]);
            `CHK(fp, 1'b1, "exit pulse")
            `CHK(fst, ex_tab[i], "exit state")
        end
        host.bypass();
        `CHK(byp, 1'b1, "bypass")
        `CHK(ccdis, 1'b1, "cc disable")
        `CHK(cfg, 8'h20, "config out")
        host.access(1'b1, 7'h05, 8'h00, 8'h11);
        `CHK(host.last_ack, 1'b0, "foreign ack")
        host.rd8(8'h00);
        `CHK(host.last_rd, 8'h6a, "foreign write")
        // soft register reset then hard reset
        host.wr8(8'h02, 8'h02);
        `CHK(por, 1'b0, "no por")
        foreach (rows[i])
        begin
            if (rows[i].a > 8'h03)
                continue;
            host.rd8(rows[i].a);
            `CHK(host.last_rd, (rows[i].a == 8'h02) ? 8'ha0 : ((rows[i].a == 8'h00) ? 8'h60 : 8'h00), "soft reset")
        end
        host.wr8(8'h00, 8'hd0);
        host.wr8(8'h02, 8'h01);
        `CHK(por, 1'b1, "por pulse")
        `CHK(vmv, 13'h10fe, "por volt")
        @(negedge clk);
        `CHK(por, 1'b0, "por clears")
        // mid-run line reset
        host.wr8(8'h01, 8'hff);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(ccm, 5'h05, "reset cc")
        `CHK(rdata, 8'h00, "reset rdata")
        arst_n <= 1'b1;
        host.rd8(8'h01);
        `CHK(host.last_rd, 8'h00, "reset cur")
        end_sim();
    end
endmodule
`undef CHK
`default_nettype wire

// *** verification/ccr_host.sv ***
/*
 Host model standing on the command side of the charger register bank.
 Assumes the bench clock and the one-strobe-per-access byte port of the bank.
*/
`timescale 1ns/1ps
`default_nettype none
module ccr_host (
    input  wire logic       clk,
    input  wire logic       ack,
    input  wire logic [7:0] rdata,
    output logic      [6:0] slv_addr,
    output logic      [7:0] reg_addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    logic [7:0] last_rd;
    logic       last_ack;

    // idle lines at time zero
    initial
    begin
        slv_addr = 7'h04;
        reg_addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // one strobe cycle, then released lines flip so stale values never match
    task automatic access(input logic w, input logic [6:0] sa, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge clk);
        slv_addr <= sa;
        reg_addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        slv_addr <= ~sa;
        reg_addr <= ~a;
        wdata <= ~d;
        @(negedge clk);
        last_ack = ack;
        last_rd = rdata;
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, 7'h04, a, d);
    endtask

    task automatic rd8(input logic [7:0] a);
        access(1'b0, 7'h04, a, 8'h00);
    endtask

    // only the four documented states are forced; stop needs a good input
    task automatic force_state(input logic [3:0] s, input logic vin_ok);
        if (s == 4'hf && !vin_ok)
            return;
        if (s == 4'hf || s == 4'h3 || s == 4'h1 || s == 4'h2)
            wr8(8'h02, {s, 4'h8});
    endtask

    // stop and sleep have their own way back, test and shipping share start
    task automatic leave(input logic [3:0] s);
        logic [3:0] nx;
        if (s == 4'hf)
            nx = 4'hc;
        else if (s == 4'h2)
            nx = 4'h8;
        else
            nx = 4'ha;
        wr8(8'h02, {nx, 4'h8});
    endtask

    // bypass needs headroom off, plus threshold, cc off
    task automatic bypass();
        wr8(8'h00, 8'h6a);
        wr8(8'h03, 8'h20);
    endtask
endmodule
`default_nettype wire
